// ### hdl/hrb_pkg.sv
// Constants, field positions and types shared by the haptic register bank.
package hrb_pkg;
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CONFIG  = 8'h01;
  localparam logic [7:0] ADDR_CONTROL = 8'h02;
  localparam logic [7:0] ADDR_SLOT0   = 8'h03;
  localparam logic [7:0] ADDR_SLOT7   = 8'h0A;
  localparam logic [7:0] ADDR_QUEUE   = 8'h0B;
  localparam logic [7:0] ADDR_PAGE    = 8'hFF;

  localparam int STAT_ILLEGAL_BIT = 2;
  localparam int STAT_EMPTY_BIT   = 1;
  localparam int STAT_FULL_BIT    = 0;
  localparam int CFG_ID_LSB       = 3;
  localparam int CFG_SRC_BIT      = 2;
  localparam int CFG_GAIN_LSB     = 0;
  localparam int CTL_RST_BIT      = 7;
  localparam int CTL_STBY_BIT     = 6;
  localparam int CTL_TMO_LSB      = 2;
  localparam int CTL_OVR_BIT      = 1;
  localparam int CTL_GO_BIT       = 0;

  localparam logic [7:0] STATUS_RST  = 8'h02;
  localparam logic [7:0] CONTROL_RST = 8'h40;
  localparam logic [7:0] SLOT_RST    = 8'h00;
  localparam logic [7:0] PAGE_RST    = 8'h00;
  localparam logic [1:0] GAIN_RST    = 2'h0;
  localparam logic [1:0] TMO_RST     = 2'h0;
  // Arbitrary neutral identifier value.
  localparam logic [3:0] PART_ID_DEFAULT = 4'hA;

  localparam int QUEUE_DEPTH = 100;
  localparam int SLOT_COUNT  = 8;

  localparam int CLK_PERIOD_NS    = 25;
  localparam int IDLE_STEP_MS     = 5;
  localparam int IDLE_STEP_CYCLES = IDLE_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam int IDLE_W           = 24;

  localparam logic [9:0] GAIN_V_25   = 10'd25;
  localparam logic [9:0] GAIN_V_50   = 10'd50;
  localparam logic [9:0] GAIN_V_75   = 10'd75;
  localparam logic [9:0] GAIN_V_100  = 10'd100;
  localparam logic [9:0] GAIN_DB_288 = 10'd288;
  localparam logic [9:0] GAIN_DB_348 = 10'd348;
  localparam logic [9:0] GAIN_DB_384 = 10'd384;
  localparam logic [9:0] GAIN_DB_407 = 10'd407;

  typedef enum logic [1:0] {
    SEQ_IDLE  = 2'b00,
    SEQ_START = 2'b01,
    SEQ_WAIT  = 2'b11
  } hrb_seq_t;
endpackage

// ### hdl/hrb_register_bank.sv
// Byte-wide register bank with sample queue, sequencer and idle timer.
//
// Contract
// - Status bit 2 shows illegal generator operation.
// - Status bit 1 shows empty queue, resets 1.
// - Full flag bit 0; full queue drops writes.
// - Config bit 2 selects digital or analog source.
// - Gain code decodes to volts or dB.
// - Sequencer plays slots until zero or eight.
// - Standby bit resets 1; zero makes device active.
// - Idle timeout code gives 5-20 ms delay.
// - Force-on bit keeps output stages enabled.
`timescale 1ns/1ps
`default_nettype none
module hrb_register_bank #(
  parameter int         QUEUE_DEPTH      = hrb_pkg::QUEUE_DEPTH,
  parameter int         IDLE_STEP_CYCLES = hrb_pkg::IDLE_STEP_CYCLES,
  parameter logic [3:0] PART_ID          = hrb_pkg::PART_ID_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       illegal_op,
  input  wire logic       seq_done,
  output logic            seq_play,
  output logic      [7:0] seq_id,
  output logic            seq_busy,
  input  wire logic       sample_pop,
  output logic            sample_valid,
  output logic      [7:0] sample_data,
  output logic            standby,
  output logic            source_select,
  output logic      [1:0] gain_code,
  output logic      [9:0] gain_level,
  output logic            stage_enable
);
  import hrb_pkg::*;

  localparam int PW = $clog2(QUEUE_DEPTH);
  localparam int CW = $clog2(QUEUE_DEPTH + 1);

  function automatic logic [9:0] gain_decode(input logic src, input logic [1:0] code);
    logic [9:0] v;
    v = GAIN_V_25;
    case ({src, code})
      3'b000:  v = GAIN_V_25;
      3'b001:  v = GAIN_V_50;
      3'b010:  v = GAIN_V_75;
      3'b011:  v = GAIN_V_100;
      3'b100:  v = GAIN_DB_288;
      3'b101:  v = GAIN_DB_348;
      3'b110:  v = GAIN_DB_384;
      3'b111:  v = GAIN_DB_407;
      default: v = GAIN_V_25;
    endcase
    return v;
  endfunction

  function automatic logic [IDLE_W-1:0] idle_load(input logic [1:0] code);
    return IDLE_W'((int'(code) + 1) * IDLE_STEP_CYCLES);
  endfunction

  logic            soft_rst_q;
  logic            src_q;
  logic [1:0]      gain_q;
  logic            stby_q;
  logic [1:0]      tmo_q;
  logic            ovr_q;
  logic            go_q;
  logic [7:0]      slot_q [SLOT_COUNT];
  logic [7:0]      page_q;
  logic [7:0]      mem_q [QUEUE_DEPTH];
  logic [PW-1:0]   wr_ptr_q;
  logic [PW-1:0]   rd_ptr_q;
  logic [CW-1:0]   cnt_q;
  logic [IDLE_W-1:0] idle_q;
  hrb_seq_t        state_q;
  logic [2:0]      idx_q;
  logic [7:0]      rdata_q;

  wire       clr       = reset | soft_rst_q;
  wire       page0     = page_q == PAGE_RST;
  wire       wr_cfg    = reg_wr & page0 & (reg_addr == ADDR_CONFIG);
  wire       wr_ctl    = reg_wr & page0 & (reg_addr == ADDR_CONTROL);
  wire       in_slots  = (reg_addr >= ADDR_SLOT0) & (reg_addr <= ADDR_SLOT7);
  wire [2:0] slot_sel  = 3'(reg_addr - ADDR_SLOT0);
  wire       wr_slot   = reg_wr & page0 & in_slots;
  wire       q_full    = cnt_q == CW'(QUEUE_DEPTH);
  wire       q_empty   = cnt_q == '0;
  wire       q_push    = reg_wr & page0 & (reg_addr == ADDR_QUEUE) & ~q_full;
  wire       q_pop     = sample_pop & ~q_empty;
  wire       q_drained = q_pop & ~q_push & (cnt_q == CW'(1));
  wire [7:0] next_id   = slot_q[3'(idx_q + 3'd1)];
  wire       last_slot = (idx_q == 3'(SLOT_COUNT - 1)) | (next_id == 8'h00);
  // Finish on zero slot or eighth slot.
  wire       seq_finish = ((state_q == SEQ_IDLE) & go_q & (slot_q[0] == 8'h00))
                        | ((state_q == SEQ_WAIT) & go_q & seq_done & last_slot);
  // Host write of go wins over self-clear.
  wire       go_d      = wr_ctl ? reg_wdata[CTL_GO_BIT] : (go_q & ~seq_finish);

  wire [7:0] status_word  = {5'h00, illegal_op, q_empty, q_full};
  wire [7:0] config_word  = {1'b0, PART_ID, src_q, gain_q};
  wire [7:0] control_word = {1'b0, stby_q, 2'b00, tmo_q, ovr_q, go_q};
  wire [7:0] rd_mux =
      (reg_addr == ADDR_PAGE)                ? page_q :
      ~page0                                 ? 8'h00 :
      (reg_addr == ADDR_STATUS)              ? status_word :
      (reg_addr == ADDR_CONFIG)              ? config_word :
      (reg_addr == ADDR_CONTROL)             ? control_word :
      in_slots                               ? slot_q[slot_sel] :
                                               8'h00;

  always_ff @(posedge clk)
  begin
    if (reset)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= wr_ctl & reg_wdata[CTL_RST_BIT] & ~soft_rst_q;
  end

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      src_q   <= CONTROL_RST[CFG_SRC_BIT] & 1'b0;
      gain_q  <= GAIN_RST;
      stby_q  <= CONTROL_RST[CTL_STBY_BIT];
      tmo_q   <= TMO_RST;
      ovr_q   <= CONTROL_RST[CTL_OVR_BIT];
      go_q    <= CONTROL_RST[CTL_GO_BIT];
      page_q  <= PAGE_RST;
      rdata_q <= 8'h00;
    end
    else
    begin
      if (wr_cfg)
      begin
        src_q  <= reg_wdata[CFG_SRC_BIT];
        gain_q <= reg_wdata[CFG_GAIN_LSB +: 2];
      end
      if (wr_ctl)
      begin
        stby_q <= reg_wdata[CTL_STBY_BIT];
        tmo_q  <= reg_wdata[CTL_TMO_LSB +: 2];
        ovr_q  <= reg_wdata[CTL_OVR_BIT];
      end
      go_q <= go_d;
      if (reg_wr & (reg_addr == ADDR_PAGE))
        page_q <= reg_wdata;
      if (reg_rd)
        rdata_q <= rd_mux;
    end
  end

  generate
    for (genvar i = 0; i < SLOT_COUNT; i++)
    begin : g_slot
      always_ff @(posedge clk)
      begin
        if (clr)
          slot_q[i] <= SLOT_RST;
        else if (wr_slot && slot_sel == 3'(i))
          slot_q[i] <= reg_wdata;
      end
    end
    for (genvar j = 0; j < QUEUE_DEPTH; j++)
    begin : g_mem
      always_ff @(posedge clk)
      begin
        if (clr)
          mem_q[j] <= 8'h00;
        else if (q_push && wr_ptr_q == PW'(j))
          mem_q[j] <= reg_wdata;
      end
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q    <= '0;
    end
    else
    begin
      if (q_push)
        wr_ptr_q <= (wr_ptr_q == PW'(QUEUE_DEPTH - 1)) ? '0 : PW'(wr_ptr_q + 1'b1);
      if (q_pop)
        rd_ptr_q <= (rd_ptr_q == PW'(QUEUE_DEPTH - 1)) ? '0 : PW'(rd_ptr_q + 1'b1);
      if (q_push & ~q_pop)
        cnt_q <= CW'(cnt_q + 1'b1);
      else if (q_pop & ~q_push)
        cnt_q <= CW'(cnt_q - 1'b1);
    end
  end

  // Idle delay after the queue drains.
  always_ff @(posedge clk)
  begin
    if (clr)
      idle_q <= '0;
    else if (q_drained)
      idle_q <= idle_load(tmo_q);
    else if (q_push)
      idle_q <= '0;
    else if (idle_q != '0)
      idle_q <= IDLE_W'(idle_q - 1'b1);
  end

  always_ff @(posedge clk)
  begin
    if (clr)
    begin
      state_q <= SEQ_IDLE;
      idx_q   <= 3'd0;
    end
    else
    begin
      case (state_q)
        SEQ_IDLE:
        begin
          idx_q <= 3'd0;
          if (go_q && slot_q[0] != 8'h00)
            state_q <= SEQ_START;
        end
        SEQ_START:
          state_q <= go_q ? SEQ_WAIT : SEQ_IDLE;
        SEQ_WAIT:
        begin
          if (!go_q || (seq_done && last_slot))
            state_q <= SEQ_IDLE;
          else if (seq_done)
          begin
            idx_q   <= 3'(idx_q + 3'd1);
            state_q <= SEQ_START;
          end
        end
        default:
          state_q <= SEQ_IDLE;
      endcase
    end
  end

  assign reg_rdata     = rdata_q;
  assign seq_play      = state_q == SEQ_START;
  assign seq_id        = slot_q[idx_q];
  assign seq_busy      = state_q != SEQ_IDLE;
  assign sample_valid  = ~q_empty;
  assign sample_data   = mem_q[rd_ptr_q];
  assign standby       = stby_q;
  assign source_select = src_q;
  assign gain_code     = gain_q;
  assign gain_level    = gain_decode(src_q, gain_q);
  assign stage_enable  = ovr_q | (~stby_q & (~q_empty | (idle_q != '0) | seq_busy));

  default clocking cb @(posedge clk); endclocking
  default disable iff (clr);

  a_full_refuses: assert property (q_full && !sample_pop |=> cnt_q == $past(cnt_q))
    else $error("write accepted into a full queue");
  a_illegal_read: assert property (reg_rd && page0 && reg_addr == ADDR_STATUS |=>
    reg_rdata[STAT_ILLEGAL_BIT] == $past(illegal_op))
    else $error("illegal flag read wrong");
  a_empty_read: assert property (reg_rd && page0 && reg_addr == ADDR_STATUS |=>
    reg_rdata[STAT_EMPTY_BIT] == $past(cnt_q == '0))
    else $error("empty flag read wrong");
  a_source_write: assert property (wr_cfg |=> source_select == $past(reg_wdata[CFG_SRC_BIT]))
    else $error("source select not updated");
  a_gain_top: assert property (gain_code == 2'h3 |->
    gain_level == (source_select ? GAIN_DB_407 : GAIN_V_100))
    else $error("top gain code decoded wrong");
  a_seq_last: assert property (state_q == SEQ_WAIT && seq_done && idx_q == 3'd7 && !wr_ctl
    |=> !go_q && state_q == SEQ_IDLE)
    else $error("sequencer ran past the eighth slot");
  a_seq_nonzero: assert property (seq_play |-> seq_id != 8'h00 ##1 !seq_play)
    else $error("zero identifier played");
  a_standby_reset: assert property (disable iff (1'b0) $fell(clr) |-> standby)
    else $error("standby not set after reset");
  a_idle_load: assert property (q_drained |=> idle_q == idle_load($past(tmo_q)))
    else $error("idle delay not loaded");
  a_force_on: assert property (wr_ctl && reg_wdata[CTL_OVR_BIT] |=> stage_enable [*2])
    else $error("force-on did not hold stages enabled");
  a_reserved_zero: assert property (reg_rd && page0 && reg_addr == ADDR_CONTROL |=>
    reg_rdata[7] == 1'b0 && reg_rdata[5:4] == 2'b00)
    else $error("reserved control bits read nonzero");
endmodule
`default_nettype wire

// ### tb/hrb_synth_model.sv
// Behavioural waveform synthesizer that answers each play request.
`timescale 1ns/1ps
`default_nettype none
module hrb_synth_model (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        seq_play,
  input  wire logic [7:0]  seq_id,
  input  wire logic [3:0]  dly,
  output logic             seq_done,
  output logic      [23:0] log_q,
  output logic      [3:0]  plays_q
);
  logic [3:0] cnt_q;
  logic       run_q;
  // Ends each waveform after a delay chosen by the bench.
  always_ff @(posedge clk)
  begin
    seq_done <= 1'b0;
    if (reset)
    begin
      log_q <= 24'h0;
      plays_q <= 4'h0;
      run_q <= 1'b0;
      cnt_q <= 4'h0;
    end
    else if (seq_play)
    begin
      log_q <= {log_q[15:0], seq_id};
      plays_q <= plays_q + 4'h1;
      cnt_q <= dly;
      run_q <= 1'b1;
    end
    else if (run_q && cnt_q == 4'h0)
    begin
      seq_done <= 1'b1;
      run_q <= 1'b0;
    end
    else if (run_q)
      cnt_q <= cnt_q - 4'h1;
  end
endmodule
`default_nettype wire

// ### tb/test_haptic_driver_register_bank.sv
// Self-checking bench for the haptic register bank.
`timescale 1ns/1ps
`default_nettype none
module test_haptic_driver_register_bank;
  import hrb_pkg::*;
  localparam int STEP = 10;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, illegal_op = 0, sample_pop = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, seq_id, sample_data, v, w;
  logic seq_play, seq_busy, sample_valid, standby, source_select, stage_enable, seq_done;
  logic [1:0] gain_code;
  logic [9:0] gain_level;
  logic [3:0] dly = 0, plays_q, np;
  logic [23:0] log_q;
  logic [7:0] q [QUEUE_DEPTH];
  int failures = 0, comparisons = 0, i, j, k, n, r;
  always #12.5 clk = ~clk;
  hrb_register_bank #(.IDLE_STEP_CYCLES(STEP)) hrb_register_bank_i (.clk, .reset,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .illegal_op, .seq_done,
    .seq_play, .seq_id, .seq_busy, .sample_pop, .sample_valid, .sample_data,
    .standby, .source_select, .gain_code, .gain_level, .stage_enable);
  hrb_synth_model hrb_synth_model_i (.clk, .reset, .seq_play, .seq_id, .dly,
    .seq_done, .log_q, .plays_q);
  function automatic logic [9:0] gl(input logic s, input logic [1:0] c);
    logic [9:0] t [8] = '{GAIN_V_25, GAIN_V_50, GAIN_V_75, GAIN_V_100,
      GAIN_DB_288, GAIN_DB_348, GAIN_DB_384, GAIN_DB_407};
    return t[{s, c}];
  endfunction
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    tick();
    d = reg_rdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    rd(a, d);
    chk(nm, e, d);
  endtask
  task automatic pop();
    @(posedge clk);
    sample_pop <= 1'b1;
    @(posedge clk);
    sample_pop <= 1'b0;
  endtask
  task automatic conclude();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #(25 * 40000);
    failures++;
    conclude();
  end
  initial
  begin
    r = $urandom(32'hA222FE68);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    tick();
    chk("standby", 1, standby);
    chk("gain_level", GAIN_V_25, gain_level);
    rdchk(ADDR_STATUS, STATUS_RST, "status");
    rdchk(ADDR_CONTROL, CONTROL_RST, "control");
    rdchk(ADDR_QUEUE, 8'h00, "queue port");
    rdchk(8'h0C, 8'h00, "unmapped");
    wr(ADDR_STATUS, 8'hFF);
    rdchk(ADDR_STATUS, STATUS_RST, "status");
    wr(ADDR_CONTROL, 8'h70);
    rdchk(ADDR_CONTROL, 8'h40, "control");
    $display("test reset done");
    for (i = 0; i < 8; i++)
    begin
      w = 8'($urandom);
      w[2:0] = 3'(i);
      wr(ADDR_CONFIG, w);
      rd(ADDR_CONFIG, v);
      chk("config", {1'b0, PART_ID_DEFAULT, w[2:0]}, v);
      chk("source", w[2], source_select);
      chk("gain_code", w[1:0], gain_code);
      chk("gain_level", gl(w[2], w[1:0]), gain_level);
    end
    @(posedge clk) illegal_op <= 1'b1;
    rdchk(ADDR_STATUS, 8'h06, "status");
    @(posedge clk) illegal_op <= 1'b0;
    $display("test config done");
    for (i = 0; i < QUEUE_DEPTH; i++)
    begin
      q[i] = 8'($urandom);
      wr(ADDR_QUEUE, q[i]);
    end
    rdchk(ADDR_STATUS, 8'h01, "status");
    wr(ADDR_QUEUE, 8'hEE);
    for (i = 0; i < QUEUE_DEPTH; i++)
    begin
      tick();
      chk("sample_data", q[i], sample_data);
      pop();
    end
    tick();
    chk("sample_valid", 0, sample_valid);
    rdchk(ADDR_STATUS, 8'h02, "status");
    $display("test queue done");
    np = 0;
    for (n = 3; n <= 8; n += 5)
    begin
      for (j = 0; j < 8; j++)
        wr(ADDR_SLOT0 + 8'(j), (j < n) ? 8'(j + 1) : 8'h00);
      @(posedge clk) dly <= 4'($urandom % 8);
      wr(ADDR_CONTROL, 8'h01);
      repeat (3) @(posedge clk);
      for (k = 0; k < 400 && seq_busy === 1'b1; k++)
        tick();
      np = np + 4'(n);
      tick();
      chk("plays", np, plays_q);
      chk("ids", {8'(n - 2), 8'(n - 1), 8'(n)}, log_q);
      rdchk(ADDR_CONTROL, 8'h00, "control");
    end
    $display("test sequencer done");
    for (i = 0; i < 4; i++)
    begin
      wr(ADDR_CONTROL, 8'(i << 2));
      wr(ADDR_QUEUE, 8'h5A);
      pop();
      repeat ((i + 1) * STEP - 3) @(posedge clk);
      tick();
      chk("stage_enable", 1, stage_enable);
      repeat (6) @(posedge clk);
      tick();
      chk("stage_enable", 0, stage_enable);
    end
    wr(ADDR_CONTROL, 8'h42);
    tick();
    chk("stage_enable", 1, stage_enable);
    chk("standby", 1, standby);
    wr(ADDR_CONTROL, 8'h00);
    tick();
    chk("stage_enable", 0, stage_enable);
    chk("standby", 0, standby);
    $display("test power done");
    wr(ADDR_CONFIG, 8'h07);
    wr(ADDR_PAGE, 8'h01);
    wr(ADDR_CONFIG, 8'h00);
    tick();
    chk("source", 1, source_select);
    rdchk(ADDR_CONFIG, 8'h00, "paged config");
    rdchk(ADDR_PAGE, 8'h01, "page");
    wr(ADDR_PAGE, 8'h00);
    wr(ADDR_SLOT0, 8'h11);
    wr(ADDR_CONTROL, 8'h80);
    tick();
    chk("standby", 1, standby);
    chk("source", 0, source_select);
    rdchk(ADDR_CONFIG, {1'b0, PART_ID_DEFAULT, 3'h0}, "config");
    rdchk(ADDR_SLOT0, SLOT_RST, "slot");
    rdchk(ADDR_CONTROL, CONTROL_RST, "control");
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    tick();
    chk("standby", 1, standby);
    rdchk(ADDR_STATUS, STATUS_RST, "status");
    $display("test page and reset done");
    conclude();
  end
endmodule
`default_nettype wire
